/* File: src/temp_event_and_readout.v */
// Operation
// - event pin is comparator or interrupt, enabled
// - event pin polarity follows polarity setting
// - above flag sets when temperature exceeds upper
// - above flag clears at upper minus hysteresis
// - below flag sets under lower minus hysteresis
// - shutdown holds event pin as before
// - interrupt critical event held until below hysteresis
// - hysteresis writes ignored while any lock set
// - word read high byte first, then low
// - temperature two's complement, quarter degree steps
// - top magnitude bit weighs 128 degrees
// - finer resolution bits always read zero
// - top three bits are trip status
// - trip flags ignore event and clear settings
// - both window flags zero means inside window
// - clear-event clears interrupt only, reads zero
// - hysteresis codes 0, 1.5, 3, 6 degrees
// - critical-only asserts event on critical only
`timescale 1ns/1ps
`include "temp_event_defs.vh"

module temp_event_and_readout (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // conversion result from the converter, same clock
  input  wire [10:0] temp_in,
  input  wire        temp_valid,
  // trip values, quarter-degree two's complement
  input  wire [10:0] upper_limit,
  input  wire [10:0] lower_limit,
  input  wire [10:0] critical_limit,
  // configuration write port, same clock
  input  wire        cfg_wr,
  input  wire        cfg_event_mode,
  input  wire        cfg_event_pol,
  input  wire        cfg_event_en,
  input  wire        cfg_crit_only,
  input  wire [1:0]  cfg_hyst,
  input  wire        clear_event,
  input  wire        alarm_lock_set,
  input  wire        crit_lock_set,
  input  wire        shutdown,
  // status
  output reg  [15:0] temperature_reading,
  output reg         event_status,
  output reg  [1:0]  hyst_sel,
  output reg         alarm_lock,
  output reg         crit_lock,
  // event pin, open drain
  output wire        event_o,
  output wire        event_oe,
  // serial readout pins
  input  wire        scl,
  input  wire        rd_frame,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe
);

  // ----------------------------------------------------------------------
  // configuration and locks
  // ----------------------------------------------------------------------
  reg        mode_reg;
  reg        pol_reg;
  reg        en_reg;
  reg        crit_only_reg;
  wire       any_lock;

  assign any_lock = alarm_lock | crit_lock;

  // locks only fall at power-on reset, so software cannot undo them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_lock    <= 1'b0;
      crit_lock     <= 1'b0;
      mode_reg      <= 1'b0;
      pol_reg       <= 1'b0;
      en_reg        <= 1'b0;
      crit_only_reg <= 1'b0;
      hyst_sel      <= `RST_HYS;
    end else begin
      if (alarm_lock_set)
        alarm_lock <= 1'b1;
      if (crit_lock_set)
        crit_lock <= 1'b1;
      if (cfg_wr && !any_lock) begin
        mode_reg <= cfg_event_mode;
        pol_reg  <= cfg_event_pol;
        en_reg   <= cfg_event_en;
        hyst_sel <= cfg_hyst;
      end
      // critical-only answers to the alarm lock alone
      if (cfg_wr && !alarm_lock)
        crit_only_reg <= cfg_crit_only;
    end
  end

  // ----------------------------------------------------------------------
  // hysteresis size and signed compare operands
  // ----------------------------------------------------------------------
  reg  [11:0] hys_steps;

  // quarter-degree steps for each code
  // 1.5, 3 and 6 degrees are 6, 12 and 24 steps
  always @* begin
    case (hyst_sel)
      `HYS_OFF: hys_steps = `HYS_STEPS_OFF;
      `HYS_1P5: hys_steps = `HYS_STEPS_1P5;
      `HYS_3P0: hys_steps = `HYS_STEPS_3P0;
      `HYS_6P0: hys_steps = `HYS_STEPS_6P0;
      default:  hys_steps = `HYS_STEPS_OFF;
    endcase
  end

  // one extra bit so that limit minus hysteresis never wraps
  wire signed [11:0] t_s     = {temp_in[10], temp_in};
  wire signed [11:0] up_s    = {upper_limit[10], upper_limit};
  wire signed [11:0] lo_s    = {lower_limit[10], lower_limit};
  wire signed [11:0] cr_s    = {critical_limit[10], critical_limit};
  wire signed [11:0] hys_s   = hys_steps;
  wire signed [11:0] up_hys  = up_s - hys_s;
  wire signed [11:0] lo_hys  = lo_s - hys_s;
  wire signed [11:0] cr_hys  = cr_s - hys_s;

  // ----------------------------------------------------------------------
  // trip flags
  // ----------------------------------------------------------------------
  reg         crit_flag;
  reg         above_flag;
  reg         below_flag;
  reg  [10:0] temp_reg;
  reg         crit_next;
  reg         above_next;
  reg         below_next;

  // next flag values with hysteresis on the falling-temperature edge only
  // critical edge shares the window hysteresis
  always @* begin
    crit_next  = crit_flag;
    above_next = above_flag;
    below_next = below_flag;
    if (t_s >= cr_s)
      crit_next = 1'b1;
    else if (t_s < cr_hys)
      crit_next = 1'b0;
    if (t_s > up_s)
      above_next = 1'b1;
    else if (t_s <= up_hys)
      above_next = 1'b0;
    if (t_s < lo_hys)
      below_next = 1'b1;
    else if (t_s >= lo_s)
      below_next = 1'b0;
  end

  // flags depend on the result, limits and hysteresis, never on event settings
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_flag  <= 1'b0;
      above_flag <= 1'b0;
      below_flag <= 1'b0;
      temp_reg   <= `RST_TEMP;
    end else if (temp_valid && !shutdown) begin
      crit_flag  <= crit_next;
      above_flag <= above_next;
      below_flag <= below_next;
      temp_reg   <= temp_in;
    end
  end

  // ----------------------------------------------------------------------
  // temperature word
  // ----------------------------------------------------------------------
  // sign in bit 12, so bit 11 weighs 128 degrees
  always @* begin
    temperature_reading = {crit_flag, above_flag, below_flag,
                           temp_reg,
                           `TW_FINE_ZERO};
  end

  // ----------------------------------------------------------------------
  // event generation
  // ----------------------------------------------------------------------
  reg  int_pend;
  reg  event_next;
  wire window_change;
  wire cmp_active;

  // any window edge is an interrupt cause unless critical-only;
  // only collected in interrupt mode, so a mode switch starts clean
  assign window_change = temp_valid && !shutdown && mode_reg && !crit_only_reg &&
                         ((above_next != above_flag) || (below_next != below_flag));

  assign cmp_active = crit_only_reg ? crit_flag
                                    : (crit_flag | above_flag | below_flag);

  // set beats clear, so a trip in the clear cycle is kept
  // comparator mode keeps nothing pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      int_pend <= 1'b0;
    else if (window_change)
      int_pend <= 1'b1;
    else if (!mode_reg)
      int_pend <= 1'b0;
    else if (clear_event)
      int_pend <= 1'b0;
  end

  // critical trip in interrupt mode cannot be cleared away
  always @* begin
    if (!en_reg)
      event_next = 1'b0;
    else if (mode_reg)
      event_next = int_pend | crit_flag;
    else
      event_next = cmp_active;
  end

  // status frozen in shutdown so the pin keeps its level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      event_status <= 1'b0;
    else if (!shutdown)
      event_status <= event_next;
  end

  // open drain: only a low level is driven
  // active-high idles low and draws pull-up current all the while
  wire event_level = event_status ? pol_reg : ~pol_reg;
  assign event_o  = 1'b0;
  assign event_oe = ~event_level;

  // ----------------------------------------------------------------------
  // readout pin synchronisers
  // ----------------------------------------------------------------------
  reg [1:0] scl_sync;
  reg [1:0] frame_sync;
  reg [1:0] sda_sync;
  reg       scl_d;
  reg       frame_d;

  // two flops before use, third stage only for edge finding
  // sda is synchronised but no logic reads it; the shifter ignores it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync   <= 2'b11;
      frame_sync <= 2'b00;
      sda_sync   <= 2'b11;
      scl_d      <= 1'b1;
      frame_d    <= 1'b0;
    end else begin
      scl_sync   <= {scl_sync[0], scl};
      frame_sync <= {frame_sync[0], rd_frame};
      sda_sync   <= {sda_sync[0], sda_i};
      scl_d      <= scl_sync[1];
      frame_d    <= frame_sync[1];
    end
  end

  wire scl_fall   = scl_d & ~scl_sync[1];
  wire frame_rise = frame_sync[1] & ~frame_d;
  wire frame_on   = frame_sync[1];

  // ----------------------------------------------------------------------
  // word shifter, most significant bit first
  // ----------------------------------------------------------------------
  reg [15:0] shift_reg;
  reg [4:0]  bit_cnt;
  reg        busy;

  // word is snapshotted so a conversion cannot tear the two bytes
  // frame low aborts a read; the next frame takes a fresh snapshot
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `RST_WORD;
      bit_cnt   <= `RD_CNT_ZERO;
      busy      <= 1'b0;
    end else if (!frame_on) begin
      busy    <= 1'b0;
      bit_cnt <= `RD_CNT_ZERO;
    end else if (frame_rise) begin
      shift_reg <= temperature_reading;
      bit_cnt   <= `RD_CNT_ZERO;
      busy      <= 1'b1;
    end else if (busy && scl_fall) begin
      shift_reg <= {shift_reg[14:0], 1'b0};
      bit_cnt   <= bit_cnt + 5'h01;
      if (bit_cnt == `RD_BITS - 5'h01)
        busy <= 1'b0;
    end
  end

  // sda drives low for zero bits, released otherwise
  assign sda_o  = 1'b0;
  assign sda_oe = busy & ~shift_reg[15];

endmodule // temp_event_and_readout

/* File: src/temp_event_defs.vh */
`ifndef TEMP_EVENT_DEFS_VH
`define TEMP_EVENT_DEFS_VH

// ----------------------------------------------------------------------
// temperature word layout
// ----------------------------------------------------------------------
`define TW_WIDTH        16
`define TW_CRIT_BIT     15
`define TW_ABOVE_BIT    14
`define TW_BELOW_BIT    13
`define TW_TEMP_MSB     12
`define TW_TEMP_LSB     2
`define TEMP_WIDTH      11
`define TW_FINE_ZERO    2'b00

// ----------------------------------------------------------------------
// hysteresis codes and sizes in quarter-degree steps
// ----------------------------------------------------------------------
`define HYS_OFF         2'b00
`define HYS_1P5         2'b01
`define HYS_3P0         2'b10
`define HYS_6P0         2'b11
`define HYS_STEPS_OFF   12'h000
`define HYS_STEPS_1P5   12'h006
`define HYS_STEPS_3P0   12'h00c
`define HYS_STEPS_6P0   12'h018

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_HYS         2'b00
`define RST_TEMP        11'h000
`define RST_WORD        16'h0000

// ----------------------------------------------------------------------
// readout sequencing
// ----------------------------------------------------------------------
`define RD_BITS         5'h10
`define RD_CNT_ZERO     5'h00

`endif

/* File: tb/temp_host_model.sv */
`timescale 1ns/1ps
module temp_host_model (
  // serial pins
  output logic scl,
  output logic rd_frame,
  input  wire  sda
);
  // ----------------------------------------
  // host side of the readout link
  // ----------------------------------------
  // idle: clock parked high, no frame open
  initial begin
    scl = 1'b1;
    rd_frame = 1'b0;
  end
  // clock only toggles inside a frame; the 16th fall releases the line
  task read_word(output logic [15:0] w);
    rd_frame = 1'b1;
    #800;
    for (int i = 15; i >= 0; i--) begin
      w[i] = sda;
      scl = 1'b0;
      #400;
      scl = 1'b1;
      #400;
    end
    rd_frame = 1'b0;
  endtask
endmodule // temp_host_model

/* File: tb/temp_event_chk.sv */
`timescale 1ns/1ps
module temp_event_chk (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // observed ports
  input wire [10:0] temp_in,
  input wire        temp_valid,
  input wire [10:0] upper_limit,
  input wire [10:0] lower_limit,
  input wire [10:0] critical_limit,
  input wire        cfg_wr,
  input wire        cfg_event_pol,
  input wire [1:0]  cfg_hyst,
  input wire        shutdown,
  input wire [15:0] temperature_reading,
  input wire        event_status,
  input wire [1:0]  hyst_sel,
  input wire        alarm_lock,
  input wire        crit_lock,
  input wire        event_oe
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pol_q;
  // polarity as accepted; locked writes must not move it
  always @(posedge clk or negedge rst_n)
    if (!rst_n) pol_q <= 1'b0;
    else if (cfg_wr && !alarm_lock && !crit_lock) pol_q <= cfg_event_pol;
  sequence conv_s;
    temp_valid && !shutdown;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  fine_zero_a: assert property (temperature_reading[1:0] == 2'b00)
    else $error("fine bits not zero");
  pin_level_a: assert property (event_oe == (event_status ^ pol_q))
    else $error("event pin level wrong");
  above_set_a: assert property (conv_s ##0 $signed(temp_in) > $signed(upper_limit)
    |=> temperature_reading[14]) else $error("above flag not set");
  below_clear_a: assert property (conv_s ##0 $signed(temp_in) >= $signed(lower_limit)
    |=> !temperature_reading[13]) else $error("below flag not clear");
  crit_set_a: assert property (conv_s ##0 $signed(temp_in) >= $signed(critical_limit)
    |=> temperature_reading[15]) else $error("critical flag not set");
  temp_word_a: assert property (conv_s |=> temperature_reading[12:2] == $past(temp_in))
    else $error("temperature field wrong");
  sd_hold_a: assert property (shutdown [*3] |-> $stable(event_status))
    else $error("event moved in shutdown");
  hyst_lock_a: assert property (cfg_wr && (alarm_lock || crit_lock) |=> $stable(hyst_sel))
    else $error("locked hysteresis changed");
  hyst_load_a: assert property (cfg_wr && !alarm_lock && !crit_lock
    |=> hyst_sel == $past(cfg_hyst)) else $error("hysteresis not loaded");
endmodule // temp_event_chk

bind temp_event_and_readout temp_event_chk i_temp_event_chk (.*);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, temp_valid = 1'b0, cfg_wr = 1'b0, shutdown = 1'b0;
  logic cfg_event_mode = 1'b0, cfg_event_pol = 1'b0, cfg_event_en = 1'b0;
  logic cfg_crit_only = 1'b0, clear_event = 1'b0, alarm_lock_set = 1'b0, crit_lock_set = 1'b0;
  logic [1:0] cfg_hyst = 2'h0;
  logic [10:0] temp_in = 11'h000, upper_limit = 11'h0c8;
  logic [10:0] lower_limit = 11'h028, critical_limit = 11'h190;
  logic [10:0] hs [4] = '{11'h000, 11'h006, 11'h00c, 11'h018};
  wire [15:0] temperature_reading;
  wire [1:0] hyst_sel;
  wire event_status, alarm_lock, crit_lock, event_o, event_oe, sda_o, sda_oe, scl, rd_frame;
  // pulled-up lines; the event pin has this device as its only driver
  wire event_pin = event_oe ? event_o : 1'b1;
  wire sda_i = sda_oe ? sda_o : 1'b1;
  logic [15:0] w;
  logic [2:0] h;
  int n_errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  temp_event_and_readout i_temp_event_and_readout (.*);
  temp_host_model i_temp_host_model (.scl(scl), .rd_frame(rd_frame), .sda(sda_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one conversion, then the whole word against the expected flags
  task conv(input [10:0] t, input [2:0] f);
    @(negedge clk) temp_in = t;
    temp_valid = 1'b1;
    @(negedge clk) temp_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk(temperature_reading, {f, t, 2'b00});
  endtask
  // fields: mode, polarity, enable, critical-only, hysteresis
  task cfg(input [5:0] c);
    @(negedge clk);
    {cfg_event_mode, cfg_event_pol, cfg_event_en, cfg_crit_only, cfg_hyst} = c;
    cfg_wr = 1'b1;
    @(negedge clk) cfg_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task conclude;
    $display("n_errors %0d n_compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  // a hang would stall the pipeline waits; generous margin over a ~34 us run
  initial begin
    #1000000;
    n_errors++;
    conclude;
  end
  // main test sequence
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk(temperature_reading, 16'h0000);
    chk({hyst_sel, alarm_lock, crit_lock}, 4'h0);
    for (h = 0; h < 4; h++) begin
      cfg({4'b0010, h[1:0]});
      chk(hyst_sel, h[1:0]);
      conv(11'h0c9, 3'b010);
      chk(event_pin, 1'b0);
      conv(11'h0c9 - hs[h], 3'b010);
      conv(11'h0c8 - hs[h], 3'b000);
      chk(event_pin, 1'b1);
      conv(11'h028 - hs[h], 3'b000);
      conv(11'h027 - hs[h], 3'b001);
      conv(11'h027, 3'b001);
      conv(11'h028, 3'b000);
    end
    conv(11'h200, 3'b110);
    conv(11'h7fc, 3'b001);
    cfg({4'b1010, 2'b10});
    conv(11'h0c8, 3'b000);
    chk(event_status, 1'b1);
    @(negedge clk) clear_event = 1'b1;
    @(negedge clk) clear_event = 1'b0;
    repeat (2) @(negedge clk);
    chk(event_status, 1'b0);
    chk(temperature_reading, 16'h0320);
    conv(11'h190, 3'b110);
    @(negedge clk) clear_event = 1'b1;
    @(negedge clk) clear_event = 1'b0;
    repeat (2) @(negedge clk);
    chk(event_status, 1'b1);
    conv(11'h184, 3'b110);
    conv(11'h183, 3'b010);
    chk(event_status, 1'b0);
    cfg({4'b0110, 2'b10});
    chk(event_pin, 1'b1);
    cfg({4'b0100, 2'b10});
    chk({event_status, event_pin}, 2'b00);
    cfg({4'b0011, 2'b10});
    chk(event_status, 1'b0);
    conv(11'h190, 3'b110);
    chk(event_status, 1'b1);
    @(negedge clk) shutdown = 1'b1;
    temp_in = 11'h000;
    temp_valid = 1'b1;
    @(negedge clk) temp_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk(event_status, 1'b1);
    chk(temperature_reading, 16'hc640);
    shutdown = 1'b0;
    i_temp_host_model.read_word(w);
    chk(w, 16'hc640);
    @(negedge clk) {alarm_lock_set, crit_lock_set} = 2'b11;
    @(negedge clk) {alarm_lock_set, crit_lock_set} = 2'b00;
    cfg({4'b0010, 2'b00});
    chk({hyst_sel, alarm_lock, crit_lock}, 4'hb);
    conclude;
  end
endmodule // tb
